// >>> shared/php_pkg.sv
package php_pkg;
    // ==========================================================
    // bus types found at detection
    typedef enum logic [2:0] {
        BUS_NONE = 3'b000, // not yet identified
        BUS_SEP_DED = 3'b001, // separate strobes, dedicated address
        BUS_SEP_MUX = 3'b010, // separate strobes, multiplexed address
        BUS_COM_DED = 3'b011, // common strobe, dedicated address
        BUS_COM_MUX = 3'b100, // common strobe, multiplexed address
        BUS_HSK = 3'b101 // multiplexed with wait handshake
    } bus_type;
    // ==========================================================
    // widths and strap patterns on address lines 2..0
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [2:0] STRAP_SEP_MUX = 3'b011;
    localparam logic [2:0] STRAP_COM_MUX = 3'b010;
    localparam logic [1:0] STRAP_HSK = 2'b11;
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    // cycles the host holds straps before starting accesses
    localparam int SETUP_NS = 64;
    localparam int CLK_NS = 8;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
endpackage : php_pkg

// >>> shared/php_if.sv
`timescale 1ns/1ps
interface php_if;
    // ==========================================================
    // host port pins, split into input/output/enable
    logic latch_pin; // ale / as / address strobe (active low in hsk)
    logic read_strobe_n; // read strobe or data strobe
    logic write_strobe_n; // write strobe or read_not_write
    logic chip_select_n; // chip select, or inhibit in hsk
    logic [2:0] addr; // address lines driven by host
    logic [2:0] addr_oe; // host drive enable per address line
    logic wait_n; // device wait output on address line 0
    logic wait_oe; // device enable for wait output
    logic [7:0] data_h; // host data out
    logic data_h_oe; // host drives data
    logic [7:0] data_d; // device data out
    logic data_d_oe; // device drives data
    modport device (
        input latch_pin, read_strobe_n, write_strobe_n, chip_select_n,
        input addr, addr_oe, data_h, data_h_oe,
        output wait_n, wait_oe, data_d, data_d_oe
    );
    modport host (
        output latch_pin, read_strobe_n, write_strobe_n, chip_select_n,
        output addr, addr_oe, data_h, data_h_oe,
        input wait_n, wait_oe, data_d, data_d_oe
    );
endinterface : php_if

// >>> verilog/php_device.sv
// Functional notes
// - reset clears mode, redetects from pins
// - sep strobes dedicated: address from lines
// - sep mux: strap 011, latch while high
// - common ded: data strobe plus direction
// - common mux: strap 010, latch while high
// - hsk: strap 11x, latch low, wait out
// - hsk: inactive chip select inhibits strobe
// - hsk without inhibit: chip select grounded
// - wait pin floats until hsk address strobe falls
// - first strobe fall activates wait
// - address reads return no valid data
`timescale 1ns/1ps
module php_device (
    input wire logic CLK_I, // 125 MHz clock
    input wire logic NRST_I, // async reset, active low
    php_if.device BUS, // host port pins
    input wire logic [7:0] RD_DATA_I, // register read data
    output logic [5:0] ADDR_O, // register address of access
    output logic [7:0] WR_DATA_O, // write data
    output logic WR_O, // one-cycle write pulse
    output logic RD_O, // one-cycle read pulse
    output logic [2:0] TYPE_O // detected bus type
);
    // ==========================================================
    // pin synchronisers, two flops each
    // reset leaves every synced pin low; the type is still unknown
    // then, so no strobe can be decoded from those levels
    logic [14:0] s1_ff; // first stage, read only by s2
    logic [14:0] s2_ff; // second stage, safe to use
    logic [14:0] raw; // packed pin view
    assign raw = {BUS.latch_pin, BUS.read_strobe_n, BUS.write_strobe_n,
                  BUS.chip_select_n, BUS.addr & BUS.addr_oe, BUS.data_h};
    // sync all pins into the clock domain
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s1_ff <= 15'h0000;
            s2_ff <= 15'h0000;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end
    logic lat; // latch pin level
    logic rd_n; // read / data strobe
    logic wr_n; // write / direction
    logic cs_n; // chip select
    logic [2:0] a; // address lines
    logic [7:0] d; // data lines
    assign {lat, rd_n, wr_n, cs_n, a, d} = s2_ff;
    // ==========================================================
    // detection: pipeline delay plus settle before sampling
    // a strap that moves after detection is ignored on purpose
    php_pkg::bus_type type_ff; // current bus type
    logic [3:0] cnt_ff; // settle counter
    logic lat_d_ff; // previous latch level
    // detect once, hold until reset; wait for straps to settle
    // through the synchroniser before trusting them
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            type_ff <= php_pkg::BUS_NONE;
            cnt_ff <= 4'h0;
        end else if (type_ff == php_pkg::BUS_NONE) begin
            if (cnt_ff != 4'(php_pkg::SETUP_CYC)) begin
                cnt_ff <= cnt_ff + 4'h1;
            end else if (a[2:1] == php_pkg::STRAP_HSK) begin
                type_ff <= php_pkg::BUS_HSK;
            end else if (a == php_pkg::STRAP_SEP_MUX && !lat) begin
                type_ff <= php_pkg::BUS_SEP_MUX;
            end else if (a == php_pkg::STRAP_COM_MUX && !lat) begin
                type_ff <= php_pkg::BUS_COM_MUX;
            end else if (lat && rd_n && !wr_n) begin
                // idle common bus: direction line rests low (write)
                type_ff <= php_pkg::BUS_COM_DED;
            end else if (lat) begin
                type_ff <= php_pkg::BUS_SEP_DED;
            end
        end
    end
    // ==========================================================
    // address capture
    logic [5:0] adr_ff; // latched address
    logic mux; // multiplexed bus type other than hsk
    assign mux = type_ff == php_pkg::BUS_SEP_MUX ||
                 type_ff == php_pkg::BUS_COM_MUX;
    // transparent latch modelled as capture while strobe level holds
    // a dedicated bus never reads this register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            adr_ff <= php_pkg::ADDR_RST;
        end else if (mux && lat) begin
            adr_ff <= d[5:0];
        end else if (type_ff == php_pkg::BUS_HSK && !lat) begin
            adr_ff <= d[5:0];
        end
    end
    // ==========================================================
    // strobe decode per type
    logic strobe; // access strobe active, qualified
    logic is_rd; // access is a read
    logic [5:0] acc_adr; // address of this access
    // defaults at the top keep every path assigned
    always_comb begin
        strobe = 1'b0;
        is_rd = 1'b0;
        acc_adr = adr_ff;
        unique case (type_ff)
            php_pkg::BUS_SEP_DED, php_pkg::BUS_SEP_MUX: begin
                strobe = !cs_n && (!rd_n || !wr_n);
                is_rd = !rd_n;
                if (type_ff == php_pkg::BUS_SEP_DED) begin
                    acc_adr = {3'h0, a};
                end
            end
            php_pkg::BUS_COM_DED, php_pkg::BUS_COM_MUX: begin
                strobe = !cs_n && !rd_n;
                is_rd = wr_n;
                if (type_ff == php_pkg::BUS_COM_DED) begin
                    acc_adr = {3'h0, a};
                end
            end
            php_pkg::BUS_HSK: begin
                // address strobe high means a data cycle; cs gates it
                strobe = !cs_n && !rd_n && lat;
                is_rd = wr_n;
            end
            default: begin
                strobe = 1'b0; // none identified yet
            end
        endcase
    end
    // ==========================================================
    // access pulses, data path
    logic strobe_d_ff; // previous strobe
    logic wr_ff; // write pulse
    logic rd_ff; // read pulse
    logic [5:0] ao_ff; // address out
    logic [7:0] wd_ff; // write data out
    logic [7:0] dd_ff; // device data out
    logic doe_ff; // device drives data
    logic rdacc_ff; // read access in progress
    // one pulse per strobe start; address read cycles never
    // drive data (address strobe low), so host sees no answer
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            strobe_d_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            ao_ff <= php_pkg::ADDR_RST;
            wd_ff <= php_pkg::DATA_RST;
            rdacc_ff <= 1'b0;
        end else begin
            strobe_d_ff <= strobe;
            rd_ff <= strobe && !strobe_d_ff && is_rd;
            wr_ff <= strobe && !strobe_d_ff && !is_rd;
            rdacc_ff <= strobe && is_rd;
            if (strobe && !strobe_d_ff) begin
                ao_ff <= acc_adr;
                wd_ff <= d;
            end
        end
    end
    // drive data while read strobe holds
    // read data is taken one cycle after the pulse, so the
    // register side has a full cycle to answer
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dd_ff <= php_pkg::DATA_RST;
            doe_ff <= 1'b0;
        end else begin
            doe_ff <= rdacc_ff && strobe && is_rd;
            if (rd_ff) begin
                dd_ff <= RD_DATA_I;
            end
        end
    end
    // ==========================================================
    // wait output on address line 0
    logic wen_ff; // wait function active
    logic wait_ff; // wait level, low = access running
    // floats after reset; armed by first strobe fall in hsk
    // the host must not expect wait before its first address cycle
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wen_ff <= 1'b0;
            lat_d_ff <= 1'b0;
        end else begin
            lat_d_ff <= lat;
            if (type_ff == php_pkg::BUS_HSK && lat_d_ff && !lat) begin
                wen_ff <= 1'b1;
            end
        end
    end
    // wait goes high once the access has been served
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= strobe_d_ff || (!lat && lat_d_ff);
        end
    end
    assign BUS.wait_n = wait_ff;
    assign BUS.wait_oe = wen_ff;
    assign BUS.data_d = dd_ff;
    assign BUS.data_d_oe = doe_ff;
    assign ADDR_O = ao_ff;
    assign WR_DATA_O = wd_ff;
    assign WR_O = wr_ff;
    assign RD_O = rd_ff;
    assign TYPE_O = type_ff;
endmodule : php_device

// >>> verilog/php_host.sv
`timescale 1ns/1ps
module php_host (
    input wire logic CLK_I, // 125 MHz clock
    input wire logic NRST_I, // async reset, active low
    php_if.host BUS, // host port pins
    input wire logic [2:0] TYPE_I, // bus type to strap
    input wire logic REQ_I, // start access, pulse
    input wire logic RNW_I, // 1 read, 0 write
    input wire logic [5:0] ADDR_I, // register address
    input wire logic [7:0] DATA_I, // write data
    output logic [7:0] DATA_O, // read data
    output logic DONE_O, // access finished, pulse
    output logic BUSY_O // access running
);
    // ==========================================================
    // simple phased access: strap idle, address, strobe, release
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADR = 2'b01,
        ST_STB = 2'b10,
        ST_END = 2'b11
    } hstate_type;
    hstate_type st_ff; // phase
    logic [3:0] cnt_ff; // phase length counter
    logic rnw_ff; // latched direction
    logic [5:0] adr_ff; // latched address
    logic [7:0] wd_ff; // latched data
    logic [7:0] rd_ff; // captured read data
    logic done_ff; // done pulse
    logic [1:0] ws1_ff; // wait sync stage 1
    logic [1:0] ws2_ff; // wait sync stage 2
    logic [7:0] ds1_ff; // data sync stage 1
    logic [7:0] ds2_ff; // data sync stage 2
    php_pkg::bus_type t;
    assign t = php_pkg::bus_type'(TYPE_I);
    // sync device pins
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ws1_ff <= 2'h0;
            ws2_ff <= 2'h0;
            ds1_ff <= 8'h00;
            ds2_ff <= 8'h00;
        end else begin
            ws1_ff <= {BUS.wait_n, BUS.wait_oe};
            ws2_ff <= ws1_ff;
            ds1_ff <= BUS.data_d;
            ds2_ff <= ds1_ff;
        end
    end
    // phase sequencer; address, strobe and end phases last a fixed count, idle waits for REQ_I, strobe in hsk also waits for wait
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            rnw_ff <= 1'b0;
            adr_ff <= php_pkg::ADDR_RST;
            wd_ff <= php_pkg::DATA_RST;
            rd_ff <= php_pkg::DATA_RST;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            cnt_ff <= cnt_ff + 4'h1;
            unique case (st_ff)
                ST_IDLE: begin
                    cnt_ff <= 4'h0;
                    if (REQ_I) begin
                        st_ff <= ST_ADR;
                        rnw_ff <= RNW_I;
                        adr_ff <= ADDR_I;
                        wd_ff <= DATA_I;
                    end
                end
                ST_ADR: if (cnt_ff == 4'(php_pkg::SETUP_CYC)) begin
                    st_ff <= ST_STB;
                    cnt_ff <= 4'h0;
                end
                ST_STB: if (cnt_ff == 4'(php_pkg::SETUP_CYC) &&
                            (t != php_pkg::BUS_HSK || ws2_ff == 2'b11)) begin
                    st_ff <= ST_END;
                    cnt_ff <= 4'h0;
                    rd_ff <= ds2_ff;
                end
                ST_END: if (cnt_ff == 4'(php_pkg::SETUP_CYC)) begin
                    st_ff <= ST_IDLE;
                    done_ff <= 1'b1;
                end
            endcase
        end
    end
    // pin drive by type; straps held whenever address phase idle
    logic mux;
    logic hsk;
    logic com;
    logic stb;
    assign mux = t == php_pkg::BUS_SEP_MUX || t == php_pkg::BUS_COM_MUX;
    assign hsk = t == php_pkg::BUS_HSK;
    assign com = t == php_pkg::BUS_COM_DED || t == php_pkg::BUS_COM_MUX;
    assign stb = st_ff == ST_STB;
    always_comb begin
        BUS.addr = adr_ff[2:0];
        if (t == php_pkg::BUS_SEP_MUX) BUS.addr = php_pkg::STRAP_SEP_MUX;
        if (t == php_pkg::BUS_COM_MUX) BUS.addr = php_pkg::STRAP_COM_MUX;
        if (hsk) BUS.addr = {php_pkg::STRAP_HSK, 1'b0};
    end
    assign BUS.addr_oe = hsk ? 3'b110 : 3'b111;
    assign BUS.latch_pin = hsk ? (st_ff != ST_ADR)
                         : mux ? (st_ff == ST_ADR) : 1'b1;
    assign BUS.chip_select_n = hsk ? 1'b0 : !(st_ff != ST_IDLE);
    assign BUS.read_strobe_n = (com || hsk) ? !stb : !(stb && rnw_ff);
    assign BUS.write_strobe_n = (com || hsk) ? (st_ff == ST_IDLE ?
                                1'b0 : rnw_ff) : !(stb && !rnw_ff);
    assign BUS.data_h = (st_ff == ST_ADR) ? {2'b00, adr_ff} : wd_ff;
    assign BUS.data_h_oe = (mux || hsk) && st_ff == ST_ADR ||
                           !rnw_ff && st_ff != ST_IDLE;
    assign DATA_O = rd_ff;
    assign DONE_O = done_ff;
    assign BUSY_O = st_ff != ST_IDLE;
endmodule : php_host

// >>> testbench/php_port_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// pin-level checks on the port joining host and device
module php_port_checker (
    input wire logic CLK_I, // port clock
    input wire logic NRST_I, // async reset, active low
    input wire logic latch_pin, // address latch or strobe
    input wire logic read_strobe_n, // read or data strobe
    input wire logic write_strobe_n, // write strobe or direction
    input wire logic chip_select_n, // chip select
    input wire logic [2:0] addr, // host address lines
    input wire logic [2:0] addr_oe, // host address enables
    input wire logic wait_n, // device wait
    input wire logic wait_oe, // device wait enable
    input wire logic [7:0] data_h, // host data
    input wire logic data_h_oe, // host data enable
    input wire logic [7:0] data_d, // device data
    input wire logic data_d_oe // device data enable
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic hsk; // handshake straps on lines 2 and 1
    logic latch_q_ff; // latch pin one cycle ago
    logic fell_seen_ff; // a latch fall since reset
    logic [3:0] gap_ff; // cycles since read strobe was low
    assign hsk = (addr[2:1] == 2'b11) && (addr_oe[2:1] == 2'b11);
    // ==========================================================
    // remember the first address strobe fall after reset
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            latch_q_ff <= 1'b1;
            fell_seen_ff <= 1'b0;
        end else begin
            latch_q_ff <= latch_pin;
            if (latch_q_ff && !latch_pin) fell_seen_ff <= 1'b1;
        end
    end
    // saturating, so a long idle never wraps back under the limit
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) gap_ff <= 4'hf;
        else if (!read_strobe_n) gap_ff <= 4'h0;
        else if (gap_ff != 4'hf) gap_ff <= gap_ff + 4'h1;
    end
    // ==========================================================
    // assertions
    data_no_clash_a: assert property (data_d_oe |-> !data_h_oe)
        else $error("both ends drive the data lines");
    wait_after_fall_a: assert property (wait_oe |-> fell_seen_ff)
        else $error("wait driven before any strobe fall");
    wait_on_fall_a: assert property
        ($fell(latch_pin) && hsk |-> ##[1:6] wait_oe)
        else $error("wait not enabled after strobe fall");
    wait_hsk_only_a: assert property (wait_oe |-> hsk)
        else $error("wait driven outside handshake straps");
    wait_release_a: assert property
        (hsk && wait_oe && $fell(read_strobe_n) |-> ##[1:12] wait_n)
        else $error("wait never ends the access");
    addr_read_quiet_a: assert property
        (hsk && !latch_pin && !$past(latch_pin, 3) |-> !data_d_oe)
        else $error("data driven in an address cycle");
    drive_near_strobe_a: assert property (data_d_oe |-> gap_ff < 4'h6)
        else $error("data driven far from a read strobe");
    drive_read_dir_a: assert property
        (data_d_oe |-> $past(write_strobe_n, 3))
        else $error("data driven in a write");
endmodule : php_port_checker

// >>> testbench/parallel_host_port_detect_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// host end and device end joined; a second device is hand driven
module parallel_host_port_detect_tb_top;
    logic clk, nrst_n, req, rnw, wr_p, rd_p, done, busy, wr_b, rd_b;
    logic [2:0] type_sel, type_seen, type_b;
    logic [5:0] addr_in, addr_seen;
    logic [7:0] wdata, rdata, data_out, wr_data_seen, wr_data_b;
    int mismatches = 0, n_checks = 0, n_wr = 0, n_rd = 0;
    int n_pulse_b = 0, n_drive_b = 0; // faulty-side activity
    php_pkg::bus_type types [5] = '{
        php_pkg::BUS_SEP_DED,
        php_pkg::BUS_SEP_MUX,
        php_pkg::BUS_COM_DED,
        php_pkg::BUS_COM_MUX,
        php_pkg::BUS_HSK};
    php_if bus_a();
    php_if bus_b();
    php_host php_host_i (.CLK_I(clk), .NRST_I(nrst_n), .BUS(bus_a.host),
        .TYPE_I(type_sel), .REQ_I(req), .RNW_I(rnw), .ADDR_I(addr_in),
        .DATA_I(wdata), .DATA_O(data_out), .DONE_O(done), .BUSY_O(busy));
    php_device php_device_i (.CLK_I(clk), .NRST_I(nrst_n),
        .BUS(bus_a.device), .RD_DATA_I(rdata), .ADDR_O(addr_seen),
        .WR_DATA_O(wr_data_seen), .WR_O(wr_p), .RD_O(rd_p),
        .TYPE_O(type_seen));
    // second device sees a host that breaks the rules on purpose
    if (1) begin : fault_side
        php_device php_device_i (.CLK_I(clk), .NRST_I(nrst_n),
            .BUS(bus_b.device), .RD_DATA_I(rdata), .ADDR_O(),
            .WR_DATA_O(wr_data_b), .WR_O(wr_b), .RD_O(rd_b),
            .TYPE_O(type_b));
    end
    php_port_checker php_port_checker_i (.CLK_I(clk), .NRST_I(nrst_n),
        .latch_pin(bus_a.latch_pin), .read_strobe_n(bus_a.read_strobe_n),
        .write_strobe_n(bus_a.write_strobe_n), .addr(bus_a.addr),
        .chip_select_n(bus_a.chip_select_n), .addr_oe(bus_a.addr_oe),
        .wait_n(bus_a.wait_n), .wait_oe(bus_a.wait_oe),
        .data_h(bus_a.data_h), .data_h_oe(bus_a.data_h_oe),
        .data_d(bus_a.data_d), .data_d_oe(bus_a.data_d_oe));
    // ==========================================================
    // clock and pulse counting
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_p === 1'b1) n_wr++;
        if (rd_p === 1'b1) n_rd++;
        if ((wr_b | rd_b) === 1'b1) n_pulse_b++;
        if (bus_b.data_d_oe === 1'b1) n_drive_b++;
    end
    // ==========================================================
    // tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // straps are applied while reset is low, so detection sees them
    task automatic restart(input logic [2:0] t);
        @(posedge clk);
        nrst_n <= 1'b0;
        type_sel <= t;
        repeat (6) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (24) @(posedge clk);
        @(negedge clk);
    endtask : restart
    // d is the write data, or the register value served on a read
    task automatic access(input logic r, input logic [5:0] a,
                          input logic [7:0] d);
        int k;
        @(posedge clk);
        req <= 1'b1;
        rnw <= r;
        addr_in <= a;
        wdata <= d;
        rdata <= d;
        @(posedge clk);
        req <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(negedge clk);
            if (done === 1'b1) break;
        end
        if (k == 200) mismatches++;
    endtask : access
    // ==========================================================
    // main sequence: every bus type, then the faulty host
    initial begin : main_seq
        logic [5:0] aw, ar;
        logic ded;
        int i;
        {nrst_n, req, rnw, addr_in, wdata, rdata} = '0;
        type_sel = 3'h1;
        {bus_b.latch_pin, bus_b.read_strobe_n} = 2'b11;
        {bus_b.write_strobe_n, bus_b.chip_select_n} = 2'b11;
        bus_b.addr = 3'b110;
        bus_b.addr_oe = 3'b110;
        bus_b.data_h = 8'h00;
        bus_b.data_h_oe = 1'b0;
        for (i = 0; i < 5; i++) begin
            restart(types[i]);
            check(8'(type_seen), 8'(types[i]));
            ded = types[i] == php_pkg::BUS_SEP_DED ||
                  types[i] == php_pkg::BUS_COM_DED;
            aw = ded ? 6'h07 : 6'h3f;
            ar = ded ? 6'h02 : 6'h15;
            if (types[i] == php_pkg::BUS_HSK) begin
                check(8'(bus_a.wait_oe), 8'h00);
                check(8'(bus_a.chip_select_n), 8'h00);
            end
            access(1'b0, aw, 8'ha5 ^ 8'(i));
            check(8'(addr_seen), 8'(aw));
            check(wr_data_seen, 8'ha5 ^ 8'(i));
            check(8'(n_wr), 8'(i + 1));
            access(1'b1, ar, 8'h3c + 8'(i));
            check(data_out, 8'h3c + 8'(i));
            check(8'(addr_seen), 8'(ar));
            check(8'({n_rd, busy}), 8'((i + 1) * 2));
            if (types[i] == php_pkg::BUS_HSK) begin
                check(8'(bus_a.wait_oe), 8'h01);
            end else begin
                // straps move under a live device: type must hold
                type_sel <= (i == 0) ? 3'h3 : 3'h1;
                repeat (24) @(posedge clk);
            end
            check(8'(type_seen), 8'(types[i]));
        end
        check(8'(type_b), 8'(php_pkg::BUS_HSK));
        check(8'(bus_b.wait_oe), 8'h00);
        // address read: strobe while address strobe low, chip selected
        @(posedge clk);
        bus_b.latch_pin <= 1'b0;
        bus_b.chip_select_n <= 1'b0;
        repeat (4) @(posedge clk);
        bus_b.read_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        bus_b.read_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus_b.latch_pin <= 1'b1;
        bus_b.chip_select_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(8'(n_drive_b), 8'h00);
        check(8'(n_pulse_b), 8'h00);
        check(8'(bus_b.wait_oe), 8'h01);
        {bus_b.write_strobe_n, bus_b.read_strobe_n} <= 2'b00;
        bus_b.data_h_oe <= 1'b1;
        bus_b.data_h <= 8'h99;
        repeat (12) @(posedge clk);
        bus_b.read_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(8'(n_pulse_b), 8'h00);
        bus_b.chip_select_n <= 1'b0;
        repeat (4) @(posedge clk);
        bus_b.read_strobe_n <= 1'b0;
        repeat (12) @(posedge clk);
        bus_b.read_strobe_n <= 1'b1;
        repeat (12) @(posedge clk);
        check(8'(n_pulse_b), 8'h01);
        check(wr_data_b, 8'h99);
        test_done();
    end
    // cut a hang short well beyond the several hundred cycles needed
    initial begin : watchdog
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule : parallel_host_port_detect_tb_top
